/* File: shared/wfc_pkg.sv */
// shared constants of the watchdog fault counter block
package wfc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int RESET_LOW_LIMIT_S = 8;
  localparam longint RESET_LOW_LIMIT_CYCLES = longint'(RESET_LOW_LIMIT_S) * CLK_HZ;
  localparam logic [3:0] WD_ERR_LIMIT_RESET = 4'h6;
  localparam logic [3:0] GOOD_LIMIT_RESET = 4'h6;
  localparam logic [2:0] FAULT_START = 3'h1;
  localparam logic [2:0] FAULT_INTER_LEVEL0 = 3'h3;
  localparam logic [2:0] FAULT_FINAL_LEVEL0 = 3'h6;
  localparam logic [2:0] FAULT_INTER_LEVEL1 = 3'h1;
  localparam logic [2:0] FAULT_FINAL_LEVEL1 = 3'h2;
  localparam logic [3:0] WD_ERR_STEP_UP = 4'h2;
  localparam logic [3:0] WD_ERR_STEP_DOWN = 4'h1;
  localparam logic [1:0] IMPACT_RESET = 2'h1;
  localparam logic [1:0] IMPACT_FAILSAFE = 2'h2;
  // register map, byte addresses
  localparam logic [3:0] ADDR_LIMITS = 4'h0;
  localparam logic [3:0] ADDR_IMPACT = 4'h4;
  localparam logic [3:0] ADDR_ENABLE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam int SRC_ENABLE_BITS = 8;
  localparam logic [7:0] SRC_ENABLE_RESET = 8'hFF;
  typedef enum logic [1:0] {WFC_WIN_CLOSED, WFC_WIN_OPEN} wfc_window_type;
endpackage

/* File: hdl/wfc_sat_counter.sv */
// saturating up/down counter with a runtime maximum
`timescale 1ns/1ps
module wfc_sat_counter import wfc_pkg::*; #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic clear,
  input wire logic up,
  input wire logic down,
  input wire logic [WIDTH-1:0] step_up,
  input wire logic [WIDTH-1:0] step_down,
  input wire logic [WIDTH-1:0] limit,
  // value
  output logic [WIDTH-1:0] value
);
  initial begin
    if (WIDTH < 2) $error("wfc_sat_counter: WIDTH too small");
  end

  logic [WIDTH:0] sum;
  assign sum = {1'b0, value} + {1'b0, step_up};

  // saturate both ways so a burst of events never wraps the count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      value <= '0;
    end else if (load) begin
      value <= load_value;
    end else if (clear) begin
      value <= '0;
    end else if (up) begin
      value <= (sum > {1'b0, limit}) ? limit : sum[WIDTH-1:0];
    end else if (down) begin
      value <= (value > step_down) ? value - step_down : '0;
    end
  end
endmodule

/* File: hdl/wfc_reset_timer.sv */
// measures how long the reset output stays low
`timescale 1ns/1ps
module wfc_reset_timer import wfc_pkg::*; #(
  parameter longint LIMIT_CYCLES = RESET_LOW_LIMIT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // watched level
  input wire logic reset_low,
  // expiry, held until the level goes away
  output logic expired
);
  initial begin
    if (LIMIT_CYCLES < 1) $error("wfc_reset_timer: LIMIT_CYCLES must be positive");
  end

  logic [39:0] count;

  // any high moment restarts the measurement
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= '0;
      expired <= 1'b0;
    end else if (!reset_low) begin
      count <= '0;
      expired <= 1'b0;
    end else if (count >= 40'(LIMIT_CYCLES)) begin
      expired <= 1'b1;
    end else begin
      count <= count + 40'h1;
    end
  end
endmodule

/* File: hdl/wfc_top.sv */
// watchdog error filtering, fault counting and fail-safe output control
// How it works
// - debug strap keeps counters alive but blocks reset and fail-safe outputs
// - a bad refresh adds two to the watchdog error counter
// - a good refresh takes one off the watchdog error counter
// - watchdog error maximum is writable only in the init safety phase
// - each good refresh adds one to the good-refresh counter
// - good refresh with good counter at limit takes one off fault count
// - a bad refresh clears the good-refresh counter
// - good-refresh limit is writable only in the init safety phase
// - closed-window write is bad; open window follows the answer
// - open window timeout is bad; closed window silence is fine
// - fault count rises by one whenever reset or fail-safe is asserted
// - with fail-safe low, each watchdog error maximum adds one fault
// - intermediate threshold forces fail-safe low or pulses reset
// - final threshold enters deep fail-safe when the strap is grounded
// - level select picks thresholds 3/6 or 1/2, init phase only
// - reset low too long gives deep fail-safe or low-power-off sleep
// - listed fault sources each have an enable bit
// - always-counting fault sources have no enable bit and always add a fault
// - impacts 01: watchdog drives reset, fail-safe at intermediate count
// - impacts 10: watchdog drives fail-safe, reset at intermediate plus maximum
// - cold start and wake load fault count one with fail-safe low
// - init-phase bad refresh or timeout asserts both outputs, adds a fault
`timescale 1ns/1ps
module wfc_top import wfc_pkg::*; #(
  parameter longint RESET_LOW_CYCLES = RESET_LOW_LIMIT_CYCLES,
  parameter int RESET_PULSE_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // watchdog refresh events
  input wire logic window_open,
  input wire logic answer_write,
  input wire logic answer_correct,
  input wire logic window_timeout,
  input wire logic init_safety_phase,
  input wire logic wake_from_low_power_off,
  input wire logic release_word_ok,
  // straps
  input wire logic debug_strap,
  input wire logic deep_safe_strap_grounded,
  // configurable fault sources: core, analog, aux uv, ov, follow monitor, ext error
  input wire logic [SRC_ENABLE_BITS-2:0] fault_src_enableable,
  // always-counting fault sources
  input wire logic [5:0] fault_src_always,
  // outputs
  output logic reset_out_n,
  output logic failsafe_out0_n,
  output logic deep_failsafe,
  output logic low_power_off_sleep
);
  initial begin
    if (RESET_PULSE_CYCLES < 1) $error("wfc_top: RESET_PULSE_CYCLES must be positive");
  end

  // configuration registers
  logic [3:0] error_limit;
  logic [3:0] good_refresh_limit;
  logic fault_level_select;
  logic [1:0] wdog_fault_impact;
  logic [1:0] fault_count_impact;
  logic [SRC_ENABLE_BITS-1:0] source_enable;
  // counters and state
  logic [3:0] wd_error_count;
  logic [3:0] good_count;
  logic [2:0] fault_count;
  logic reset_req;
  logic failsafe_req;
  logic [7:0] pulse_count;
  logic reset_long_low;
  logic start_load;

  logic refresh_good;
  logic refresh_bad;
  logic wd_at_max;
  logic wd_hits_max;
  logic [2:0] fault_inter;
  logic [2:0] fault_final;
  logic fault_any_src;
  logic fault_up;
  logic fault_down;
  logic next_reset_req;
  logic next_failsafe_req;
  logic reset_rise;
  logic failsafe_rise;
  logic inter_reached;

  function automatic logic is_write(input logic wr, input logic [3:0] a, input logic [3:0] t);
    return wr && (a == t);
  endfunction

  // refresh classification, closed window writes always bad
  assign refresh_good = answer_write && window_open && answer_correct;
  assign refresh_bad = (answer_write && !(window_open && answer_correct))
    || (window_timeout && window_open);

  // config writes, protected outside the init phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      error_limit <= WD_ERR_LIMIT_RESET;
      good_refresh_limit <= GOOD_LIMIT_RESET;
      fault_level_select <= 1'b0;
      wdog_fault_impact <= IMPACT_RESET;
      fault_count_impact <= IMPACT_RESET;
      source_enable <= SRC_ENABLE_RESET;
    end else if (init_safety_phase) begin
      if (is_write(reg_write, reg_addr, ADDR_LIMITS)) begin
        error_limit <= reg_wdata[3:0];
        good_refresh_limit <= reg_wdata[7:4];
      end
      if (is_write(reg_write, reg_addr, ADDR_IMPACT)) begin
        fault_level_select <= reg_wdata[0];
        wdog_fault_impact <= reg_wdata[2:1];
        fault_count_impact <= reg_wdata[4:3];
      end
      if (is_write(reg_write, reg_addr, ADDR_ENABLE)) begin
        source_enable <= reg_wdata[SRC_ENABLE_BITS-1:0];
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        ADDR_LIMITS: reg_rdata <= {24'h0, good_refresh_limit, error_limit};
        ADDR_IMPACT: reg_rdata <= {27'h0, fault_count_impact, wdog_fault_impact,
          fault_level_select};
        ADDR_ENABLE: reg_rdata <= {24'h0, source_enable};
        ADDR_STATUS: reg_rdata <= {16'h0, deep_failsafe, low_power_off_sleep,
          failsafe_req, reset_req, 1'b0, fault_count, good_count, wd_error_count};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  wfc_sat_counter #(.WIDTH(4)) u_wd_error (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(1'b0),
    .load_value(4'h0),
    .clear(1'b0),
    .up(refresh_bad),
    .down(refresh_good),
    .step_up(WD_ERR_STEP_UP),
    .step_down(WD_ERR_STEP_DOWN),
    .limit(error_limit),
    .value(wd_error_count)
  );

  wfc_sat_counter #(.WIDTH(4)) u_good (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(1'b0),
    .load_value(4'h0),
    .clear(refresh_bad),
    .up(refresh_good),
    .down(1'b0),
    .step_up(4'h1),
    .step_down(4'h1),
    .limit(good_refresh_limit),
    .value(good_count)
  );

  // thresholds from the level select
  assign fault_inter = fault_level_select ? FAULT_INTER_LEVEL1 : FAULT_INTER_LEVEL0;
  assign fault_final = fault_level_select ? FAULT_FINAL_LEVEL1 : FAULT_FINAL_LEVEL0;

  // the watchdog error counter reaching its maximum is a one-cycle event
  assign wd_at_max = (wd_error_count == error_limit);
  assign wd_hits_max = refresh_bad && !wd_at_max
    && ({1'b0, wd_error_count} + {1'b0, WD_ERR_STEP_UP} >= {1'b0, error_limit});

  assign fault_any_src = (|(fault_src_enableable & source_enable[SRC_ENABLE_BITS-1:1]))
    || (|fault_src_always)
    || (init_safety_phase && refresh_bad);

  assign inter_reached = (fault_count >= fault_inter);

  // output requests, level driven by faults and impact config
  always_comb begin
    next_reset_req = reset_req;
    next_failsafe_req = failsafe_req;
    if (fault_any_src) begin
      next_reset_req = 1'b1;
      next_failsafe_req = 1'b1;
    end
    if (wd_hits_max && source_enable[0] && !init_safety_phase) begin
      if (wdog_fault_impact[0]) next_reset_req = 1'b1;
      if (wdog_fault_impact[1]) next_failsafe_req = 1'b1;
    end
    if (fault_count_impact == IMPACT_RESET && inter_reached) begin
      next_failsafe_req = 1'b1;
    end
    if (fault_count_impact == IMPACT_FAILSAFE && inter_reached && wd_at_max) begin
      next_reset_req = 1'b1;
    end
    if (reset_req && pulse_count >= 8'(RESET_PULSE_CYCLES - 1) && !fault_any_src) begin
      next_reset_req = 1'b0; // reset is a pulse, released after its length
    end
    if (failsafe_req && release_word_ok && fault_count == 3'h0 && !fault_any_src) begin
      next_failsafe_req = 1'b0;
    end
  end

  assign reset_rise = next_reset_req && !reset_req;
  assign failsafe_rise = next_failsafe_req && !failsafe_req;

  // cold start and wake both hold fail-safe and reload the fault count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      start_load <= 1'b1;
    end else begin
      start_load <= wake_from_low_power_off;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reset_req <= 1'b0;
      failsafe_req <= 1'b1;
      pulse_count <= '0;
    end else if (start_load) begin
      reset_req <= 1'b0;
      failsafe_req <= 1'b1;
      pulse_count <= '0;
    end else begin
      reset_req <= next_reset_req;
      failsafe_req <= next_failsafe_req;
      pulse_count <= reset_req ? pulse_count + 8'h1 : 8'h0;
    end
  end

  // one fault per cycle in which an output asserts or a maximum is hit while fail-safe is low
  assign fault_up = reset_rise || failsafe_rise
    || (failsafe_req && wd_hits_max && source_enable[0]);
  assign fault_down = refresh_good && (good_count >= good_refresh_limit);

  wfc_sat_counter #(.WIDTH(3)) u_fault (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(start_load),
    .load_value(FAULT_START),
    .clear(1'b0),
    .up(fault_up),
    .down(fault_down && !fault_up),
    .step_up(3'h1),
    .step_down(3'h1),
    .limit(fault_final),
    .value(fault_count)
  );

  // debug masks the pins and blocks the terminal states below; counters keep running underneath
  assign reset_out_n = !(reset_req && !debug_strap);
  assign failsafe_out0_n = !(failsafe_req && !debug_strap);

  wfc_reset_timer #(.LIMIT_CYCLES(RESET_LOW_CYCLES)) u_rst_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .reset_low(!reset_out_n),
    .expired(reset_long_low)
  );

  // terminal states are sticky until a power cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      deep_failsafe <= 1'b0;
      low_power_off_sleep <= 1'b0;
    end else if (!debug_strap) begin
      if ((fault_count >= fault_final && deep_safe_strap_grounded)
          || (reset_long_low && deep_safe_strap_grounded)) begin
        deep_failsafe <= 1'b1;
      end
      if (reset_long_low && !deep_safe_strap_grounded) begin
        low_power_off_sleep <= 1'b1;
      end
    end
  end
endmodule

/* File: test/wfc_top_asserts.sv */
// port-level checks for the watchdog fault counter block
`timescale 1ns/1ps
module wfc_top_asserts import wfc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // watched inputs
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic answer_write,
  input wire logic answer_correct,
  input wire logic init_safety_phase,
  input wire logic wake_from_low_power_off,
  input wire logic release_word_ok,
  input wire logic debug_strap,
  input wire logic deep_safe_strap_grounded,
  // watched outputs
  input wire logic [31:0] reg_rdata,
  input wire logic reset_out_n,
  input wire logic failsafe_out0_n,
  input wire logic deep_failsafe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a settled debug strap keeps both outputs released
  a_debug_blocks_out: assert property (debug_strap && $past(debug_strap) |->
    reset_out_n && failsafe_out0_n) else $error("output asserted in debug mode");
  // fail-safe leaves reset and wake held low
  a_start_fs_low: assert property ($past(reset) |-> !failsafe_out0_n || debug_strap)
    else $error("fail-safe not low after reset");
  // the wake pulse arms the reload, which lands one edge later
  a_wake_fs_low: assert property (wake_from_low_power_off && !debug_strap |-> ##2
    !failsafe_out0_n || debug_strap) else $error("fail-safe not low after wake");
  // debug is excluded both ways: its edge also lifts the output
  a_release_needs_word: assert property ($rose(failsafe_out0_n) && !debug_strap &&
    !$past(debug_strap) |-> $past(release_word_ok)) else $error("release without word");
  a_reset_pulse_len: assert property (disable iff (reset || debug_strap)
    $fell(reset_out_n) && !$past(debug_strap) |-> (!reset_out_n)[*8])
    else $error("reset pulse too short");
  // init-phase bad answer asserts both outputs
  a_init_bad_both: assert property (init_safety_phase && answer_write && !answer_correct
    && !debug_strap |-> ##[1:3] !reset_out_n && !failsafe_out0_n)
    else $error("init fault not signalled");
  a_no_deep_supply: assert property (!deep_safe_strap_grounded |-> !deep_failsafe)
    else $error("deep fail-safe with strap at supply");
  a_fault_saturate: assert property ($past(reg_read) && $past(reg_addr) == ADDR_STATUS |->
    reg_rdata[10:8] <= 3'h6) else $error("fault count above final threshold");
  // main scenarios reached
  c_release: cover property ($rose(failsafe_out0_n));
  c_reset_pulse: cover property ($fell(reset_out_n));
  c_debug_bad: cover property (debug_strap && answer_write && !answer_correct);
endmodule

/* File: test/wfc_mcu_model.sv */
// microcontroller side: window phase and watchdog answer writes
`timescale 1ns/1ps
module wfc_mcu_model (
  // clock
  input wire logic clk_sys,
  // refresh events toward the block
  output logic window_open,
  output logic answer_write,
  output logic answer_correct,
  output logic window_timeout
);
  // idle and closed at time zero
  initial begin
    window_open = 1'b0;
    answer_write = 1'b0;
    answer_correct = 1'b0;
    window_timeout = 1'b0;
  end
  // kind 0 open good, 1 open bad, 2 closed write, 3 open timeout; random gap first
  task automatic refresh(input int kind);
    int gap;
    gap = $urandom % 4;
    window_open <= (kind != 2);
    repeat (gap + 1) @(posedge clk_sys);
    if (kind == 3) begin
      window_timeout <= 1'b1;
    end else begin
      answer_write <= 1'b1;
      answer_correct <= (kind != 1);
    end
    @(posedge clk_sys);
    window_timeout <= 1'b0;
    answer_write <= 1'b0;
    // qualifier is not held past the write, so show its inverse
    answer_correct <= ~answer_correct;
  endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench: refresh sequences against a counter model
`timescale 1ns/1ps
module tb_top;
  import wfc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic init_safety_phase = 1'b1;
  logic wake_from_low_power_off = 1'b0;
  logic release_word_ok = 1'b0;
  logic debug_strap = 1'b0;
  logic deep_safe_strap_grounded = 1'b0;
  logic window_open, answer_write, answer_correct, window_timeout;
  logic [31:0] reg_rdata, rd_val;
  logic reset_out_n, failsafe_out0_n, deep_failsafe, low_power_off_sleep;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // model: error count, good count, fault count, error limit, good limit
  int wd = 0;
  int gd = 0;
  int ft = 1;
  int el = 4;
  int gl = 6;

  // reset-low timer shortened so a stuck reset shows within the run
  wfc_top #(.RESET_LOW_CYCLES(200)) uut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .window_open, .answer_write, .answer_correct, .window_timeout,
    .init_safety_phase, .wake_from_low_power_off, .release_word_ok, .debug_strap,
    .deep_safe_strap_grounded, .fault_src_enableable(7'h00), .fault_src_always(6'h00),
    .reset_out_n, .failsafe_out0_n, .deep_failsafe, .low_power_off_sleep);
  wfc_mcu_model mcu (.clk_sys, .window_open, .answer_write, .answer_correct, .window_timeout);

  // system clock
  always #5 clk_sys = ~clk_sys;
  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // register port: one-cycle strobes, idle cycle after a write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    rd_val = reg_rdata;
    @(posedge clk_sys);
  endtask

  // outputs are looked at once the edge's updates have landed
  task automatic outs(input logic r, input logic f);
    #1;
    check(reset_out_n, r, "reset out");
    check(failsafe_out0_n, f, "failsafe out");
    @(posedge clk_sys);
  endtask

  task automatic stat();
    rd(ADDR_STATUS);
    check(rd_val[10:0], ft * 256 + gd * 16 + wd, "counters");
  endtask

  // one refresh through the partner, then the model step and a status compare
  task automatic refresh_chk(input int kind);
    mcu.refresh(kind);
    if (kind == 0) begin
      wd = (wd > 0) ? wd - 1 : 0;
      if (gd >= gl) ft = (ft > 0) ? ft - 1 : 0;
      else gd++;
    end else begin
      wd = (wd + 2 > el) ? el : wd + 2;
      gd = 0;
      if (wd == el || init_safety_phase) ft = (ft < 6) ? ft + 1 : 6;
    end
    repeat (2) @(posedge clk_sys);
    stat();
  endtask

  initial begin
    void'($urandom(61107));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    stat();
    outs(1'b1, 1'b0);
    // init phase: error limit 4, good limit 6, level 0, impacts 01
    wr(ADDR_LIMITS, 32'h64);
    wr(ADDR_IMPACT, 32'h0A);
    wr(ADDR_ENABLE, 32'hFF);
    rd(ADDR_LIMITS);
    check(rd_val, 32'h64, "limits");
    refresh_chk(1);
    outs(1'b0, 1'b0);
    // after init the limits are locked
    repeat (20) @(posedge clk_sys);
    init_safety_phase <= 1'b0;
    wr(ADDR_LIMITS, ($urandom & 32'hF0) | 32'h3);
    rd(ADDR_LIMITS);
    check(rd_val, 32'h64, "locked limits");
    for (int i = 0; i < 8; i++) refresh_chk(0);
    release_word_ok <= 1'b1;
    @(posedge clk_sys);
    release_word_ok <= 1'b0;
    outs(1'b1, 1'b1);
    // closed write, good, timeout, open bad: error count 2, 1, 3, then limit
    refresh_chk(2);
    refresh_chk(0);
    refresh_chk(3);
    refresh_chk(1);
    outs(1'b0, 1'b1);
    // step off the limit, then a wake reloads one fault
    repeat (2) mcu.refresh(0);
    repeat (30) @(posedge clk_sys);
    wake_from_low_power_off <= 1'b1;
    @(posedge clk_sys);
    wake_from_low_power_off <= 1'b0;
    rd(ADDR_STATUS);
    check(rd_val[10:8], 3'h1, "wake fault");
    outs(1'b1, 1'b0);
    // debug: counters keep moving, outputs stay released
    debug_strap <= 1'b1;
    repeat (3) mcu.refresh(1);
    rd(ADDR_STATUS);
    check(rd_val[7:4], 4'h0, "debug good count");
    outs(1'b1, 1'b1);
    check(deep_failsafe, 1'b0, "deep fail-safe with strap at supply");
    check(low_power_off_sleep, 1'b0, "sleep without long reset");
    summarize();
  end
endmodule

// port checker attached to the block
bind wfc_top wfc_top_asserts chk (.clk_sys, .reset, .reg_addr, .reg_read, .answer_write,
  .answer_correct, .init_safety_phase, .wake_from_low_power_off, .release_word_ok,
  .debug_strap, .deep_safe_strap_grounded, .reg_rdata, .reset_out_n, .failsafe_out0_n,
  .deep_failsafe);
